// ### verilog/otc_regs.svh
// Register map, field positions, reset values and timing counts of the
// optical transceiver control block.
// Assumes a 20 MHz system clock and 7-bit register addresses.
`ifndef OTC_REGS_SVH
`define OTC_REGS_SVH

// Register addresses on the 3-wire interface.
`define OTC_A_RX_CTRL1    7'h00
`define OTC_A_RX_CTRL2    7'h01
`define OTC_A_LINK_STAT   7'h02
`define OTC_A_TX_CTRL     7'h03
`define OTC_A_FAULT_A     7'h04
`define OTC_A_FAULT_B     7'h05
`define OTC_A_RX_SWING    7'h06
`define OTC_A_RX_THRESH   7'h07
`define OTC_A_BIAS_CEIL   7'h08
`define OTC_A_BIAS_LEVEL  7'h09
`define OTC_A_BIAS_INC    7'h0A
`define OTC_A_MOD_CEIL    7'h0B
`define OTC_A_MOD_LEVEL   7'h0C
`define OTC_A_MOD_INC     7'h0D
`define OTC_A_PULSE_WIDTH 7'h0E
`define OTC_A_TX_DEEMPH   7'h0F

// Receive control 1 fields.
`define OTC_F_RX_INVERT   0
`define OTC_F_OFFSET_LOOP 1
`define OTC_F_RX_DEEMPH   2
`define OTC_F_RX_OUT_EN   3
`define OTC_F_SQUELCH     4
// Receive control 2 fields.
`define OTC_F_ABSENT_EN   0
`define OTC_F_ABSENT_POL  1
`define OTC_F_RATE_SEL    2
`define OTC_F_RATE_FROM_REG 3
// Transmit control fields.
`define OTC_F_TX_INVERT   0
`define OTC_F_TX_ENABLE   1
`define OTC_F_TX_DEEMPH   2

// Reset values.
`define OTC_R_RX_CTRL1    5'h0A
`define OTC_R_RX_CTRL2    4'h1
`define OTC_R_TX_CTRL     3'h2
`define OTC_R_RX_SWING    8'h80
`define OTC_R_RX_THRESH   6'h10
`define OTC_R_BYTE        8'h00
`define OTC_R_LEVEL       9'h000

// Current ramp after reset or re-enable: one DAC step per interval.
`define OTC_CLK_PERIOD_NS 50
`define OTC_RAMP_STEP_NS  1000
`define OTC_RAMP_CYCLES   (`OTC_RAMP_STEP_NS / `OTC_CLK_PERIOD_NS)

`endif

// ### verilog/otc_pkg.sv
// Types shared by the optical transceiver control block.
// Assumes nothing beyond a SystemVerilog compiler.
package otc_pkg;

  // Phases of one 3-wire frame.
  typedef enum logic [1:0] {
    OTC_SER_ADDR,
    OTC_SER_WDATA,
    OTC_SER_RDATA,
    OTC_SER_HOLD
  } otc_ser_t;

endpackage : otc_pkg

// ### verilog/otc_step_unit.sv
// Signed incremental update of one laser current setting with ceiling check.
// Assumes the caller applies the result only on the increment access.
`timescale 1ns/1ns
module otc_step_unit #(
  parameter int LVL_W = 9,
  parameter int INC_W = 5
) (
  input  wire logic [LVL_W-1:0] cur_lvl,
  input  wire logic [INC_W-1:0] inc,
  input  wire logic [LVL_W-2:0] limit,
  output logic      [LVL_W-1:0] nxt_lvl,
  output logic                  err
);

  // The increment must be narrower than the level it adjusts.
  if (INC_W >= LVL_W || INC_W < 2) begin : g_bad_width
    $error("otc_step_unit: increment width not supported");
  end

  logic signed [LVL_W+1:0] sum;

  // Full eleven-bit sum; only the upper bits meet the ceiling.
  assign sum = $signed({2'b00, cur_lvl})
             + $signed({{(LVL_W+2-INC_W){inc[INC_W-1]}}, inc});

  // A negative result or one above the ceiling keeps the old level.
  assign err     = sum[LVL_W+1] || (sum[LVL_W:1] > {1'b0, limit});
  assign nxt_lvl = err ? cur_lvl : sum[LVL_W-1:0];

endmodule : otc_step_unit

// ### verilog/otc_ctrl.sv
// Control and status logic of the optical transceiver: 3-wire register
// slave, receiver and transmitter settings, current steps and fault latch.
// Assumes every pin input is asynchronous to SYS_CLK and that RESET is
// asserted while the supply is below the laser-off threshold.
`timescale 1ns/1ns
`include "otc_regs.svh"
module otc_ctrl #(
  parameter int RAMP_CYC = `OTC_RAMP_CYCLES
) (
  input  wire logic       SYS_CLK,
  input  wire logic       RESET,
  input  wire logic       SCL,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  input  wire logic       CSEL,
  input  wire logic       RATE_PIN,
  input  wire logic       DISABLE,
  input  wire logic       NO_INPUT_RAW,
  input  wire logic       TX_EDGE_RAW,
  input  wire logic       BIAS_MON_HIGH,
  input  wire logic       HARD_FAULT_RAW,
  output logic            RATE_HIGH,
  output logic            RX_INVERT,
  output logic            OFFSET_LOOP_ON,
  output logic            RX_DEEMPH_ON,
  output logic            RX_OUT_ON,
  output logic [7:0]      RX_SWING,
  output logic [5:0]      ABSENT_THRESH,
  output logic            NO_INPUT_FLAG,
  output logic            TX_INVERT,
  output logic [7:0]      PULSE_WIDTH,
  output logic            TX_DEEMPH_ON,
  output logic [7:0]      TX_DEEMPH_LEVEL,
  output logic            LASER_ON,
  output logic [8:0]      BIAS_DAC,
  output logic [8:0]      MOD_DAC,
  output logic            FAULT_OUT,
  output logic            FAULT_OE
);

  if (RAMP_CYC < 1 || RAMP_CYC > 65535) begin : g_bad_ramp
    $error("otc_ctrl: RAMP_CYC out of range");
  end

  // Every check in this block runs on the system clock and sleeps in reset.
  default clocking chk_clk @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);

  localparam int P_SCL  = 0;
  localparam int P_SDA  = 1;
  localparam int P_CSEL = 2;
  localparam int P_RATE = 3;
  localparam int P_DIS  = 4;
  localparam int P_NOIN = 5;
  localparam int P_EDGE = 6;
  localparam int P_BIAS_MONITOR_PIN = 7;
  localparam int P_HARD = 8;
  localparam int NPIN   = 9;

  logic [NPIN-1:0]  pin_raw;
  logic [NPIN-1:0]  pin_m_q;
  logic [NPIN-1:0]  pin_s_q;
  logic [NPIN-1:0]  pin_d_q;
  otc_pkg::otc_ser_t ser_q;
  logic [2:0]       bit_cnt_q;
  logic [7:0]       shift_q;
  logic [6:0]       addr_q;
  logic [7:0]       rdata_q;
  logic [7:0]       rd_mux;
  logic [7:0]       byte_nx;
  logic             wr_go_q;
  logic [7:0]       wr_data_q;
  logic [4:0]       rxc1_q;
  logic [3:0]       rxc2_q;
  logic [2:0]       txc_q;
  logic [7:0]       blim_q;
  logic [7:0]       binc_q;
  logic [7:0]       mlim_q;
  logic [7:0]       minc_q;
  logic [8:0]       bias_q;
  logic [8:0]       mod_q;
  logic [8:0]       bias_nx;
  logic [8:0]       mod_nx;
  logic             berr_c;
  logic             merr_c;
  logic             berr_q;
  logic             merr_q;
  logic             hard_q;
  logic             soft_q;
  logic [9:0]       txde_sum;
  logic [15:0]      ramp_cnt_q;
  logic             scl_rise;
  logic             scl_fall;
  logic             dis_toggle;
  logic             los_act;
  logic             laser_en;

  // Register write strobe for one address, decoded for every writable register.
  function automatic logic wr_hit(input logic go, input logic [6:0] a,
                                  input logic [6:0] target);
    wr_hit = go && (a == target);
  endfunction : wr_hit

  // Two flops on every pin; only the second stage and its delayed copy
  // are read, so no logic sees a metastable value.
  assign pin_raw = {HARD_FAULT_RAW, BIAS_MON_HIGH, TX_EDGE_RAW, NO_INPUT_RAW,
                    DISABLE, RATE_PIN, CSEL, SDA_IN, SCL};
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      pin_m_q <= 9'h010;
      pin_s_q <= 9'h010;
      pin_d_q <= 9'h010;
    end else begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
      pin_d_q <= pin_s_q;
    end
  end

  assign scl_rise   = pin_s_q[P_SCL] && !pin_d_q[P_SCL];
  assign scl_fall   = !pin_s_q[P_SCL] && pin_d_q[P_SCL];
  assign dis_toggle = pin_s_q[P_DIS] ^ pin_d_q[P_DIS];
  assign byte_nx    = {shift_q[6:0], pin_s_q[P_SDA]};

  // Read data for the address just shifted in.
  always_comb begin
    unique case (byte_nx[6:0])
      `OTC_A_RX_CTRL1:    rd_mux = {3'h0, rxc1_q};
      `OTC_A_RX_CTRL2:    rd_mux = {4'h0, rxc2_q};
      `OTC_A_LINK_STAT:   rd_mux = {6'h00, pin_s_q[P_EDGE],
                                    pin_s_q[P_NOIN]};
      `OTC_A_TX_CTRL:     rd_mux = {5'h00, txc_q};
      `OTC_A_FAULT_A:     rd_mux = {6'h00, soft_q, hard_q};
      `OTC_A_FAULT_B:     rd_mux = {6'h00, merr_q, berr_q};
      `OTC_A_RX_SWING:    rd_mux = RX_SWING;
      `OTC_A_RX_THRESH:   rd_mux = {2'h0, ABSENT_THRESH};
      `OTC_A_BIAS_CEIL:   rd_mux = blim_q;
      `OTC_A_BIAS_LEVEL:  rd_mux = bias_q[8:1];
      `OTC_A_BIAS_INC:    rd_mux = binc_q;
      `OTC_A_MOD_CEIL:    rd_mux = mlim_q;
      `OTC_A_MOD_LEVEL:   rd_mux = mod_q[8:1];
      `OTC_A_MOD_INC:     rd_mux = minc_q;
      `OTC_A_PULSE_WIDTH: rd_mux = PULSE_WIDTH;
      `OTC_A_TX_DEEMPH:   rd_mux = TX_DEEMPH_LEVEL;
      default:            rd_mux = 8'h00;
    endcase
  end

  // Frame engine: CSEL low aborts and rearms; the first byte is a read
  // flag and address, the second is data shifted MSB first, in on SCL rise or out on SCL fall.
  always_ff @(posedge SYS_CLK) begin
    wr_go_q <= 1'b0;
    if (RESET || !pin_s_q[P_CSEL]) begin
      ser_q     <= otc_pkg::OTC_SER_ADDR;
      bit_cnt_q <= 3'h0;
      shift_q   <= 8'h00;
      SDA_OE    <= 1'b0;
      if (RESET) begin
        addr_q    <= 7'h00;
        rdata_q   <= 8'h00;
        wr_data_q <= 8'h00;
      end
    end else begin
      unique case (ser_q)
        otc_pkg::OTC_SER_ADDR: begin
          if (scl_rise) begin
            shift_q   <= byte_nx;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
              addr_q  <= byte_nx[6:0];
              rdata_q <= rd_mux;
              ser_q   <= byte_nx[7] ? otc_pkg::OTC_SER_RDATA
                                    : otc_pkg::OTC_SER_WDATA;
            end
          end
        end
        otc_pkg::OTC_SER_WDATA: begin
          if (scl_rise) begin
            shift_q   <= byte_nx;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
              wr_data_q <= byte_nx;
              wr_go_q   <= 1'b1;
              ser_q     <= otc_pkg::OTC_SER_HOLD;
            end
          end
        end
        otc_pkg::OTC_SER_RDATA: begin
          // Open drain: enable pulls low for a zero bit.
          if (scl_fall) begin
            SDA_OE  <= !rdata_q[7];
            rdata_q <= {rdata_q[6:0], 1'b0};
          end
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
              ser_q <= otc_pkg::OTC_SER_HOLD;
            end
          end
        end
        otc_pkg::OTC_SER_HOLD: begin
          if (scl_fall) begin
            SDA_OE <= 1'b0;
          end
        end
      endcase
    end
  end

  // The data pin is open drain, so the level it drives is always low.
  always_ff @(posedge SYS_CLK) begin
    SDA_OUT <= 1'b0;
  end

  // Plain configuration registers.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rxc1_q          <= `OTC_R_RX_CTRL1;
      rxc2_q          <= `OTC_R_RX_CTRL2;
      txc_q           <= `OTC_R_TX_CTRL;
      RX_SWING        <= `OTC_R_RX_SWING;
      ABSENT_THRESH   <= `OTC_R_RX_THRESH;
      blim_q          <= `OTC_R_BYTE;
      binc_q          <= `OTC_R_BYTE;
      mlim_q          <= `OTC_R_BYTE;
      minc_q          <= `OTC_R_BYTE;
      PULSE_WIDTH     <= `OTC_R_BYTE;
    end else begin
      if (wr_hit(wr_go_q, addr_q, `OTC_A_RX_CTRL1)) rxc1_q <= wr_data_q[4:0];
      if (wr_hit(wr_go_q, addr_q, `OTC_A_RX_CTRL2)) rxc2_q <= wr_data_q[3:0];
      if (wr_hit(wr_go_q, addr_q, `OTC_A_TX_CTRL))  txc_q  <= wr_data_q[2:0];
      if (wr_hit(wr_go_q, addr_q, `OTC_A_RX_SWING)) begin
        RX_SWING <= wr_data_q;
      end
      if (wr_hit(wr_go_q, addr_q, `OTC_A_RX_THRESH)) begin
        ABSENT_THRESH <= wr_data_q[5:0];
      end
      if (wr_hit(wr_go_q, addr_q, `OTC_A_BIAS_CEIL)) blim_q <= wr_data_q;
      if (wr_hit(wr_go_q, addr_q, `OTC_A_BIAS_INC))  binc_q <= wr_data_q;
      if (wr_hit(wr_go_q, addr_q, `OTC_A_MOD_CEIL))  mlim_q <= wr_data_q;
      if (wr_hit(wr_go_q, addr_q, `OTC_A_MOD_INC))   minc_q <= wr_data_q;
      if (wr_hit(wr_go_q, addr_q, `OTC_A_PULSE_WIDTH)) begin
        PULSE_WIDTH <= wr_data_q;
      end
    end
  end

  // Step units see the increment being written this cycle.
  otc_step_unit #(.LVL_W(9), .INC_W(5)) u_bias_step (
    .cur_lvl (bias_q),
    .inc     (wr_data_q[4:0]),
    .limit   (blim_q),
    .nxt_lvl (bias_nx),
    .err     (berr_c)
  );
  otc_step_unit #(.LVL_W(9), .INC_W(5)) u_mod_step (
    .cur_lvl (mod_q),
    .inc     (wr_data_q[4:0]),
    .limit   (mlim_q),
    .nxt_lvl (mod_nx),
    .err     (merr_c)
  );

  // Current settings: direct writes keep bit 0, steps move all nine bits.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      bias_q <= `OTC_R_LEVEL;
      mod_q  <= `OTC_R_LEVEL;
    end else begin
      if (wr_hit(wr_go_q, addr_q, `OTC_A_BIAS_LEVEL)) begin
        bias_q <= {wr_data_q, bias_q[0]};
      end else if (wr_hit(wr_go_q, addr_q, `OTC_A_BIAS_INC)) begin
        bias_q <= bias_nx;
      end
      if (wr_hit(wr_go_q, addr_q, `OTC_A_MOD_LEVEL)) begin
        mod_q <= {wr_data_q, mod_q[0]};
      end else if (wr_hit(wr_go_q, addr_q, `OTC_A_MOD_INC)) begin
        mod_q <= mod_nx;
      end
    end
  end

  // Deemphasis follows each accepted modulation step, saturating at the
  // ends of its range rather than wrapping.
  assign txde_sum = {2'b00, TX_DEEMPH_LEVEL}
                  + {{5{wr_data_q[4]}}, wr_data_q[4:0]};
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      TX_DEEMPH_LEVEL <= `OTC_R_BYTE;
    end else if (wr_hit(wr_go_q, addr_q, `OTC_A_TX_DEEMPH)) begin
      TX_DEEMPH_LEVEL <= wr_data_q;
    end else if (wr_hit(wr_go_q, addr_q, `OTC_A_MOD_INC) && !merr_c) begin
      if (txde_sum[9]) TX_DEEMPH_LEVEL <= 8'h00;
      else if (txde_sum[8]) TX_DEEMPH_LEVEL <= 8'hFF;
      else TX_DEEMPH_LEVEL <= txde_sum[7:0];
    end
  end

  // Sticky flags: a new event wins over a clear in the same cycle.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      berr_q <= 1'b0;
      merr_q <= 1'b0;
      hard_q <= 1'b0;
      soft_q <= 1'b0;
    end else begin
      berr_q <= (wr_hit(wr_go_q, addr_q, `OTC_A_BIAS_INC) && berr_c)
             || (berr_q && !dis_toggle);
      merr_q <= (wr_hit(wr_go_q, addr_q, `OTC_A_MOD_INC) && merr_c)
             || (merr_q && !dis_toggle);
      hard_q <= pin_s_q[P_HARD] || (hard_q && !dis_toggle);
      soft_q <= pin_s_q[P_BIAS_MONITOR_PIN] || (soft_q && !dis_toggle);
    end
  end

  // Receiver and transmitter controls, all presented from flops.
  assign los_act = rxc2_q[`OTC_F_ABSENT_EN] && pin_s_q[P_NOIN];
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      RATE_HIGH      <= 1'b0;
      RX_INVERT      <= 1'b0;
      OFFSET_LOOP_ON <= 1'b0;
      RX_DEEMPH_ON   <= 1'b0;
      RX_OUT_ON      <= 1'b0;
      NO_INPUT_FLAG  <= 1'b0;
      TX_INVERT      <= 1'b0;
      TX_DEEMPH_ON   <= 1'b0;
    end else begin
      RATE_HIGH      <= rxc2_q[`OTC_F_RATE_FROM_REG]
                      ? rxc2_q[`OTC_F_RATE_SEL] : pin_s_q[P_RATE];
      RX_INVERT      <= rxc1_q[`OTC_F_RX_INVERT];
      OFFSET_LOOP_ON <= rxc1_q[`OTC_F_OFFSET_LOOP];
      RX_DEEMPH_ON   <= rxc1_q[`OTC_F_RX_DEEMPH];
      RX_OUT_ON      <= rxc1_q[`OTC_F_RX_OUT_EN]
                      && !(rxc1_q[`OTC_F_SQUELCH] && los_act);
      NO_INPUT_FLAG  <= los_act ^ rxc2_q[`OTC_F_ABSENT_POL];
      TX_INVERT      <= txc_q[`OTC_F_TX_INVERT];
      TX_DEEMPH_ON   <= txc_q[`OTC_F_TX_DEEMPH];
    end
  end

  // Laser currents: off in reset, on disable or hard fault, then they
  // climb one step per interval so the laser never overshoots.
  assign laser_en = !pin_s_q[P_DIS] && txc_q[`OTC_F_TX_ENABLE] && !hard_q;
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      LASER_ON   <= 1'b0;
      BIAS_DAC   <= 9'h000;
      MOD_DAC    <= 9'h000;
      ramp_cnt_q <= 16'h0000;
      FAULT_OUT  <= 1'b0;
      FAULT_OE   <= 1'b1;
    end else begin
      LASER_ON <= laser_en;
      FAULT_OE <= !hard_q;
      if (!laser_en) begin
        BIAS_DAC   <= 9'h000;
        MOD_DAC    <= 9'h000;
        ramp_cnt_q <= 16'h0000;
      end else if (ramp_cnt_q == 16'(RAMP_CYC - 1)) begin
        ramp_cnt_q <= 16'h0000;
        if (BIAS_DAC < bias_q) BIAS_DAC <= BIAS_DAC + 9'h001;
        else BIAS_DAC <= bias_q;
        if (MOD_DAC < mod_q) MOD_DAC <= MOD_DAC + 9'h001;
        else MOD_DAC <= mod_q;
      end else begin
        ramp_cnt_q <= ramp_cnt_q + 16'h0001;
      end
    end
  end

  // Checks kept beside the logic they guard.
  chk_rx_out_gate: assert property (
    (rxc1_q[`OTC_F_RX_OUT_EN] && rxc1_q[`OTC_F_SQUELCH] && los_act)
      |=> !RX_OUT_ON)
    else $error("receive output not squelched");
  chk_flag_gate: assert property (
    !rxc2_q[`OTC_F_ABSENT_EN]
      |=> NO_INPUT_FLAG == $past(rxc2_q[`OTC_F_ABSENT_POL]))
    else $error("absent flag active while detection off");
  chk_bias_lsb: assert property (
    wr_hit(wr_go_q, addr_q, `OTC_A_BIAS_LEVEL)
      |=> bias_q == {$past(wr_data_q), $past(bias_q[0])})
    else $error("bias direct write disturbed bit 0");
  chk_mod_lsb: assert property (
    wr_hit(wr_go_q, addr_q, `OTC_A_MOD_LEVEL)
      |=> mod_q == {$past(wr_data_q), $past(mod_q[0])})
    else $error("modulation direct write disturbed bit 0");
  chk_bias_overflow: assert property (
    (wr_hit(wr_go_q, addr_q, `OTC_A_BIAS_INC) && berr_c)
      |=> $stable(bias_q) && berr_q)
    else $error("bias overflow not refused");
  chk_mod_overflow: assert property (
    (wr_hit(wr_go_q, addr_q, `OTC_A_MOD_INC) && merr_c)
      |=> $stable(mod_q) && merr_q)
    else $error("modulation overflow not refused");
  chk_laser_off: assert property (
    pin_s_q[P_DIS] |=> !LASER_ON && BIAS_DAC == 9'h000 && MOD_DAC == 9'h000)
    else $error("laser currents on while disabled");
  chk_soft_latch: assert property (
    (pin_s_q[P_BIAS_MONITOR_PIN] ##1 !dis_toggle [*2]) |-> soft_q)
    else $error("soft fault not held");
  chk_fault_clear: assert property (
    (dis_toggle && !pin_s_q[P_HARD] && !pin_s_q[P_BIAS_MONITOR_PIN])
      |=> !hard_q && !soft_q ##1 FAULT_OE)
    else $error("disable toggle did not clear faults");
  chk_ramp_slew: assert property (
    laser_en && $past(laser_en) |-> BIAS_DAC <= $past(BIAS_DAC) + 9'h001)
    else $error("bias current jumped instead of ramping");

endmodule : otc_ctrl

// ### bench/otc_host_wire.sv
// Open-drain SDA line shared by the controller and the device.
// Assumes both parties only pull low and a pull-up holds the line high.
`timescale 1ns/1ns
module otc_host_wire (
  input  wire logic host_rel,
  input  wire logic dev_pull,
  output logic      sda_line
);
  // The pull-up wins unless one party pulls low.
  assign sda_line = host_rel & ~dev_pull;
endmodule : otc_host_wire

// ### bench/testbench.sv
// Self-checking bench for the transceiver control block over 3-wire frames.
// Assumes the register map and reset values given in otc_regs.svh.
`timescale 1ns/1ns
`include "otc_regs.svh"
module testbench;
  logic       sys_clk = 1'h0;
  logic       reset   = 1'h1;
  logic       scl     = 1'h0;
  logic       csel    = 1'h0;
  logic       host_rel = 1'h1;
  logic       rate_pin = 1'h0;
  logic       disable_pin = 1'h0;
  logic       no_raw  = 1'h0;
  logic       edge_raw = 1'h0;
  logic       mon_high = 1'h0;
  logic       hard_raw = 1'h0;
  logic       sda, sda_oe, rate_high, rx_inv, loop_on, rx_de, rx_on;
  logic       no_flag, tx_inv, tx_de_on, laser_on, fault_oe;
  logic       sda_out, fault_out;
  logic [7:0] rx_swing, pulse_w, tx_de_lvl;
  logic [5:0] abs_thr;
  logic [8:0] bias_dac, mod_dac;
  int         fail_count = 0;
  int         checks = 0;
  int         cycles = 0;

  // A short ramp interval keeps the current ramp within a few frames.
  otc_ctrl #(.RAMP_CYC(2)) i_otc_ctrl (
    .SYS_CLK(sys_clk), .RESET(reset), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .CSEL(csel), .RATE_PIN(rate_pin),
    .DISABLE(disable_pin), .NO_INPUT_RAW(no_raw), .TX_EDGE_RAW(edge_raw),
    .BIAS_MON_HIGH(mon_high), .HARD_FAULT_RAW(hard_raw),
    .RATE_HIGH(rate_high), .RX_INVERT(rx_inv), .OFFSET_LOOP_ON(loop_on),
    .RX_DEEMPH_ON(rx_de), .RX_OUT_ON(rx_on), .RX_SWING(rx_swing),
    .ABSENT_THRESH(abs_thr), .NO_INPUT_FLAG(no_flag), .TX_INVERT(tx_inv),
    .PULSE_WIDTH(pulse_w), .TX_DEEMPH_ON(tx_de_on),
    .TX_DEEMPH_LEVEL(tx_de_lvl), .LASER_ON(laser_on), .BIAS_DAC(bias_dac),
    .MOD_DAC(mod_dac), .FAULT_OUT(fault_out), .FAULT_OE(fault_oe));

  otc_host_wire i_otc_host_wire (
    .host_rel(host_rel), .dev_pull(sda_oe), .sda_line(sda));

  // Free-running 20 MHz clock.
  always #25 sys_clk = ~sys_clk;

  // Cycle ceiling well above the expected length of the run.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  // Wide enough for a flag packed beside a nine-bit current value.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // One SCL period; the line is sampled late in the low half, when the
  // device answer has long settled after its two-flop synchroniser.
  task automatic clk_bit(input logic b, output logic s);
    scl <= 1'h0;
    host_rel <= b;
    cyc(4);
    s = sda;
    cyc(1);
    scl <= 1'h1;
    cyc(5);
  endtask : clk_bit

  // One whole frame: header byte, then eight data bits either way.
  task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd,
                      output logic [7:0] rdv);
    logic s;
    csel <= 1'h1;
    cyc(2);
    for (int i = 7; i >= 0; i--) clk_bit(hdr[i], s);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(hdr[7] | wd[i], s);
      rdv[i] = s;
    end
    scl <= 1'h0;
    cyc(8);
    csel <= 1'h0;
    host_rel <= 1'h1;
    // Long enough for the current ramp to climb five steps.
    cyc(10);
  endtask : xfer

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] junk;
    xfer({1'h0, a}, d, junk);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] v;
    xfer({1'h1, a}, 8'h00, v);
    check(v, exp);
  endtask : rd

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // Main sequence: reset values, receiver, transmitter, steps, faults.
  initial begin
    cyc(12);
    reset <= 1'h0;
    cyc(4);
    rd(7'h00, 8'h0A);
    rd(7'h01, 8'h01);
    rd(7'h03, 8'h02);
    rd(7'h06, 8'h80);
    rd(7'h07, 8'h10);
    rd(7'h08, 8'h00);
    check(laser_on, 1'h1);
    wr(7'h06, 8'hA5);
    check(rx_swing, 8'hA5);
    wr(7'h07, 8'h3F);
    check(abs_thr, 6'h3F);
    rd(7'h20, 8'h00);
    wr(7'h02, 8'hFF);
    rd(7'h02, 8'h00);
    wr(7'h00, 8'h1F);
    check({rx_inv, loop_on, rx_de, rx_on}, 4'hF);
    no_raw <= 1'h1;
    cyc(6);
    check(rx_on, 1'h0);
    check(no_flag, 1'h1);
    wr(7'h00, 8'h08);
    check({rx_inv, loop_on, rx_de, rx_on}, 4'h1);
    wr(7'h00, 8'h00);
    check(rx_on, 1'h0);
    wr(7'h01, 8'h03);
    check(no_flag, 1'h0);
    wr(7'h01, 8'h02);
    check(no_flag, 1'h1);
    rate_pin <= 1'h1;
    cyc(6);
    check(rate_high, 1'h1);
    wr(7'h01, 8'h08);
    check(rate_high, 1'h0);
    wr(7'h01, 8'h0C);
    check(rate_high, 1'h1);
    wr(7'h03, 8'h07);
    check({tx_inv, tx_de_on}, 2'h3);
    wr(7'h0E, 8'h5A);
    check(pulse_w, 8'h5A);
    wr(7'h03, 8'h02);
    check({tx_inv, tx_de_on}, 2'h0);
    // Ceilings first, then levels and signed steps.
    wr(7'h08, 8'h05);
    wr(7'h09, 8'h04);
    check(bias_dac, 9'h008);
    wr(7'h0A, 8'h01);
    check(bias_dac, 9'h009);
    rd(7'h09, 8'h04);
    wr(7'h0A, 8'h07);
    check(bias_dac, 9'h009);
    rd(7'h05, 8'h01);
    wr(7'h0A, 8'h18);
    check(bias_dac, 9'h001);
    wr(7'h0B, 8'h04);
    wr(7'h0F, 8'h10);
    wr(7'h0C, 8'h03);
    wr(7'h0D, 8'h03);
    check(mod_dac, 9'h009);
    check(tx_de_lvl, 8'h13);
    wr(7'h0D, 8'h02);
    check(mod_dac, 9'h009);
    rd(7'h05, 8'h03);
    wr(7'h0C, 8'h02);
    check(mod_dac, 9'h005);
    no_raw <= 1'h0;
    edge_raw <= 1'h1;
    mon_high <= 1'h1;
    cyc(6);
    mon_high <= 1'h0;
    rd(7'h02, 8'h02);
    rd(7'h04, 8'h02);
    hard_raw <= 1'h1;
    cyc(6);
    hard_raw <= 1'h0;
    cyc(6);
    check({fault_oe, laser_on}, 2'h0);
    check({sda_out, fault_out}, 2'h0);
    disable_pin <= 1'h1;
    cyc(6);
    check({laser_on, bias_dac}, 10'h000);
    disable_pin <= 1'h0;
    cyc(6);
    check(fault_oe, 1'h1);
    rd(7'h04, 8'h00);
    rd(7'h05, 8'h00);
    reset <= 1'h1;
    cyc(4);
    check({laser_on, mod_dac}, 10'h000);
    reset <= 1'h0;
    cyc(4);
    rd(7'h09, 8'h00);
    rd(7'h06, 8'h80);
    finish_test();
  end
endmodule : testbench
